// File: esie_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants of the extended stack instruction executor
// ---------------------------------------------------------------------------
package esie_pkg;

  localparam int ESIE_ADDR_W = 12;
  localparam int ESIE_PC_W = 21;

  // -------------------------------------------------------------------------
  // Opcode patterns and fields
  // -------------------------------------------------------------------------
  localparam logic [7:0] ESIE_OP_MOVE = 8'hEB;
  localparam logic [7:0] ESIE_OP_PUSH = 8'hFA;
  localparam logic [7:0] ESIE_OP_SUB = 8'hE9;
  localparam logic [15:0] ESIE_OP_CALL_WORK = 16'h0014;
  localparam logic [3:0] ESIE_WORD2_TAG = 4'hF;
  localparam logic [1:0] ESIE_SEL_RET = 2'h3;
  localparam logic [1:0] ESIE_SEL_FRAME = 2'h2;
  localparam int ESIE_MOVE_SS_BIT = 7;
  localparam int ESIE_ACCESS_BIT = 8;
  localparam int ESIE_DEST_BIT = 9;

  // -------------------------------------------------------------------------
  // Address arithmetic
  // -------------------------------------------------------------------------
  localparam logic [7:0] ESIE_ILO_LIMIT = 8'h5F;
  localparam logic [3:0] ESIE_ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ESIE_ACCESS_HIGH_BANK = 4'hF;
  localparam logic [11:0] ESIE_PTR_ONE = 12'h001;
  localparam logic [20:0] ESIE_PC_STEP = 21'h0_0002;
  localparam logic [11:0] ESIE_IND_LO_DEF = 12'hFDB;
  localparam logic [11:0] ESIE_IND_HI_DEF = 12'hFEF;
  localparam logic [7:0] ESIE_NULL_DATA = 8'h00;

  // -------------------------------------------------------------------------
  // Register map and reset values
  // -------------------------------------------------------------------------
  localparam logic [11:0] ESIE_REG_CTRL = 12'h000;
  localparam logic [11:0] ESIE_REG_PTR0 = 12'h004;
  localparam logic [11:0] ESIE_REG_PTR1 = 12'h008;
  localparam logic [11:0] ESIE_REG_PTR2 = 12'h00C;
  localparam logic [11:0] ESIE_REG_STATUS = 12'h010;
  localparam int ESIE_CTRL_EXT_BIT = 0;
  localparam int ESIE_STAT_BUSY_BIT = 0;
  localparam int ESIE_STAT_NOP_BIT = 1;
  localparam logic ESIE_CTRL_RST = 1'b0;
  localparam logic [11:0] ESIE_PTR_RST = 12'h000;

  typedef enum logic [1:0] {
    ESIE_IDLE,
    ESIE_MOVE_WR,
    ESIE_NOP
  } esie_state_t;

endpackage

// File: esie_addr_map.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Operand address resolution
// ---------------------------------------------------------------------------
module esie_addr_map
  import esie_pkg::*;
#(
  parameter logic [11:0] IND_LO = ESIE_IND_LO_DEF,
  parameter logic [11:0] IND_HI = ESIE_IND_HI_DEF
) (
  input wire logic ext_en_in,
  input wire logic [3:0] bank_select_register_in,
  input wire logic [11:0] frame_ptr_in,
  input wire logic [15:0] word_in,
  input wire logic [15:0] word2_in,
  output logic [11:0] file_addr_out,
  output logic [11:0] src_addr_out,
  output logic [11:0] dst_addr_out,
  output logic src_ind_out,
  output logic dst_ind_out
);

  function automatic logic [11:0] add_offset(input logic [11:0] base, input logic [7:0] off);
    add_offset = base + {4'h0, off};
  endfunction

  function automatic logic is_indirect(input logic [11:0] addr);
    is_indirect = (addr >= IND_LO) && (addr <= IND_HI);
  endfunction

  wire [7:0] file_op = word_in[7:0];
  wire access_sel = word_in[ESIE_ACCESS_BIT];
  wire low_op = (file_op <= ESIE_ILO_LIMIT);
  wire ilo_hit = ext_en_in && !access_sel && low_op;
  wire [11:0] access_addr = {low_op ? ESIE_ACCESS_LOW_BANK : ESIE_ACCESS_HIGH_BANK, file_op};
  wire move_ss = word_in[ESIE_MOVE_SS_BIT];

  assign file_addr_out = ilo_hit ? add_offset(frame_ptr_in, file_op) :
    access_sel ? {bank_select_register_in, file_op} : access_addr;
  assign src_addr_out = add_offset(frame_ptr_in, {1'b0, word_in[6:0]});
  assign dst_addr_out = move_ss ? add_offset(frame_ptr_in, {1'b0, word2_in[6:0]}) :
    word2_in[11:0];
  assign src_ind_out = is_indirect(src_addr_out);
  assign dst_ind_out = move_ss && is_indirect(dst_addr_out);

endmodule

// File: esie_exec.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Extended stack instruction executor
// ---------------------------------------------------------------------------
// How it works
// - Absolute move source is frame pointer plus offset.
// - Absolute move destination is 12-bit second word.
// - Indexed move adds both offsets to pointer.
// - Indirect source reads as zero, no read.
// - Indirect indexed destination suppresses the write; the source is still read.
// - Push stores literal at pointer, then decrements.
// - Subtract six-bit literal from selected pointer.
// - Select three subtracts frame pointer, then returns.
// - Extensions off: access bank or bank select.
// - Extensions on: low operands offset frame pointer.
// - Operands above limit keep access bank meaning.
// - Zero frame pointer gives plain access addresses.
// - Destination bit keeps working-register or file meaning.
// - Extensions work only with enable bit set.
// - Call through working register pushes, then jumps.
module esie_exec
  import esie_pkg::*;
#(
  parameter logic [11:0] IND_LO = ESIE_IND_LO_DEF,
  parameter logic [11:0] IND_HI = ESIE_IND_HI_DEF
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [15:0] INSTR_WORD_IN,
  input wire logic [15:0] INSTR_WORD2_IN,
  input wire logic [7:0] MEM_RD_DATA_IN,
  input wire logic [7:0] WORKING_REGISTER_IN,
  input wire logic [3:0] BANK_SELECT_REGISTER_IN,
  input wire logic [20:0] PC_IN,
  input wire logic [20:0] RETURN_STACK_TOP_IN,
  input wire logic [7:0] PC_HIGH_LATCH_IN,
  input wire logic [4:0] PC_UPPER_LATCH_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic MEM_RD_OUT,
  output logic [11:0] MEM_RD_ADDR_OUT,
  output logic MEM_WR_OUT,
  output logic [11:0] MEM_WR_ADDR_OUT,
  output logic [7:0] MEM_WR_DATA_OUT,
  output logic PC_LOAD_OUT,
  output logic [20:0] PC_VALUE_OUT,
  output logic PUSH_OUT,
  output logic [20:0] PUSH_VALUE_OUT,
  output logic FILE_VALID_OUT,
  output logic [11:0] FILE_ADDR_OUT,
  output logic FILE_TO_REG_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT
);

  // -------------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // -------------------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------------------
  function automatic logic [31:0] apb_merge(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      apb_merge[b*8 +: 8] = strb[b] ? wdata[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  logic ext_en;
  logic last_move_nop;
  logic [11:0] ptr [0:2];
  logic [11:0] next_ptr [0:2];
  esie_state_t state;
  esie_state_t next_state;

  wire sel_ctrl = (PADDR_IN == ESIE_REG_CTRL);
  wire [2:0] sel_ptr = {PADDR_IN == ESIE_REG_PTR2, PADDR_IN == ESIE_REG_PTR1,
                        PADDR_IN == ESIE_REG_PTR0};
  wire sel_status = (PADDR_IN == ESIE_REG_STATUS);
  wire mapped = sel_ctrl || (|sel_ptr) || sel_status;
  wire apb_setup = PSEL_IN && !PENABLE_IN;
  wire apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
  wire [31:0] status_word = {30'h0000_0000, last_move_nop, state != ESIE_IDLE};
  wire [31:0] rd_word = sel_ctrl ? {31'h0000_0000, ext_en} :
    sel_ptr[0] ? {20'h0_0000, ptr[0]} :
    sel_ptr[1] ? {20'h0_0000, ptr[1]} :
    sel_ptr[2] ? {20'h0_0000, ptr[2]} :
    sel_status ? status_word : 32'h0000_0000;
  wire [31:0] merged = apb_merge(rd_word, PWDATA_IN, PSTRB_IN);

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
      ext_en <= ESIE_CTRL_RST;
    end else begin
      PREADY_OUT <= apb_setup;
      PRDATA_OUT <= apb_setup ? rd_word : 32'h0000_0000;
      PSLVERR_OUT <= apb_setup && !mapped;
      if (apb_wr && sel_ctrl) begin
        ext_en <= merged[ESIE_CTRL_EXT_BIT];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Instruction decode
  // -------------------------------------------------------------------------
  logic [11:0] file_addr;
  logic [11:0] src_addr;
  logic [11:0] dst_addr;
  logic src_ind;
  logic dst_ind;

  esie_addr_map #(
    .IND_LO(IND_LO),
    .IND_HI(IND_HI)
  ) u_addr_map (
    .ext_en_in(ext_en),
    .bank_select_register_in(BANK_SELECT_REGISTER_IN),
    .frame_ptr_in(ptr[2]),
    .word_in(INSTR_WORD_IN),
    .word2_in(INSTR_WORD2_IN),
    .file_addr_out(file_addr),
    .src_addr_out(src_addr),
    .dst_addr_out(dst_addr),
    .src_ind_out(src_ind),
    .dst_ind_out(dst_ind)
  );

  wire idle = (state == ESIE_IDLE);
  wire take = idle && INSTR_VALID_IN;
  wire [7:0] op_hi = INSTR_WORD_IN[15:8];
  wire w2_ok = (INSTR_WORD2_IN[15:12] == ESIE_WORD2_TAG);
  wire do_move = take && ext_en && (op_hi == ESIE_OP_MOVE) && w2_ok;
  wire move_ss = INSTR_WORD_IN[ESIE_MOVE_SS_BIT];
  wire do_push = take && ext_en && (op_hi == ESIE_OP_PUSH);
  wire do_sub = take && ext_en && (op_hi == ESIE_OP_SUB);
  wire [1:0] sub_sel = INSTR_WORD_IN[7:6];
  wire [5:0] sub_k = INSTR_WORD_IN[5:0];
  wire do_subret = do_sub && (sub_sel == ESIE_SEL_RET);
  wire [1:0] sub_tgt = do_subret ? ESIE_SEL_FRAME : sub_sel;
  wire do_call_work = take && ext_en && (INSTR_WORD_IN == ESIE_OP_CALL_WORK);
  wire do_std = take && !do_move && !do_push && !do_sub && !do_call_work;
  wire move_wr = (state == ESIE_MOVE_WR);

  always_comb begin
    next_state = state;
    case (state)
      ESIE_IDLE: begin
        if (do_move) begin
          next_state = ESIE_MOVE_WR;
        end else if (do_subret || do_call_work) begin
          next_state = ESIE_NOP;
        end
      end
      ESIE_MOVE_WR: next_state = ESIE_IDLE;
      ESIE_NOP: next_state = ESIE_IDLE;
      default: next_state = ESIE_IDLE;
    endcase
  end

  // -------------------------------------------------------------------------
  // Pointer registers
  // -------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_ptr[i] = ptr[i];
      if (apb_wr && sel_ptr[i]) begin
        next_ptr[i] = merged[11:0];
      end
      if (do_sub && (sub_tgt == 2'(i))) begin
        next_ptr[i] = ptr[i] - {6'h00, sub_k};
      end
      if (do_push && (i == 2)) begin
        next_ptr[i] = ptr[i] - ESIE_PTR_ONE;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= '{ESIE_PTR_RST, ESIE_PTR_RST, ESIE_PTR_RST};
      state <= ESIE_IDLE;
    end else begin
      ptr <= next_ptr;
      state <= next_state;
    end
  end

  // -------------------------------------------------------------------------
  // Memory and program counter requests
  // -------------------------------------------------------------------------
  logic src_ind_q;
  logic dst_ind_q;
  logic [11:0] dst_addr_q;

  wire [7:0] move_data = src_ind_q ? ESIE_NULL_DATA : MEM_RD_DATA_IN;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      MEM_RD_OUT <= 1'b0;
      MEM_RD_ADDR_OUT <= 12'h000;
      src_ind_q <= 1'b0;
      dst_ind_q <= 1'b0;
      dst_addr_q <= 12'h000;
    end else begin
      MEM_RD_OUT <= do_move && !src_ind;
      if (do_move) begin
        MEM_RD_ADDR_OUT <= src_addr;
        src_ind_q <= src_ind;
        dst_ind_q <= dst_ind;
        dst_addr_q <= dst_addr;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      MEM_WR_OUT <= 1'b0;
      MEM_WR_ADDR_OUT <= 12'h000;
      MEM_WR_DATA_OUT <= 8'h00;
      last_move_nop <= 1'b0;
    end else begin
      MEM_WR_OUT <= (move_wr && !dst_ind_q) || do_push;
      MEM_WR_ADDR_OUT <= move_wr ? dst_addr_q : ptr[2];
      MEM_WR_DATA_OUT <= move_wr ? move_data : INSTR_WORD_IN[7:0];
      if (move_wr) begin
        last_move_nop <= dst_ind_q;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PC_LOAD_OUT <= 1'b0;
      PC_VALUE_OUT <= 21'h0_0000;
      PUSH_OUT <= 1'b0;
      PUSH_VALUE_OUT <= 21'h0_0000;
    end else begin
      PC_LOAD_OUT <= do_subret || do_call_work;
      PC_VALUE_OUT <= do_call_work ?
        {PC_UPPER_LATCH_IN, PC_HIGH_LATCH_IN, WORKING_REGISTER_IN} : RETURN_STACK_TOP_IN;
      PUSH_OUT <= do_call_work;
      PUSH_VALUE_OUT <= PC_IN + ESIE_PC_STEP;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      FILE_VALID_OUT <= 1'b0;
      FILE_ADDR_OUT <= 12'h000;
      FILE_TO_REG_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
    end else begin
      FILE_VALID_OUT <= do_std;
      FILE_ADDR_OUT <= file_addr;
      FILE_TO_REG_OUT <= INSTR_WORD_IN[ESIE_DEST_BIT];
      BUSY_OUT <= (next_state != ESIE_IDLE);
      DONE_OUT <= (take && (next_state == ESIE_IDLE)) || (!idle && (next_state == ESIE_IDLE));
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  sequence move_issue_s;
    do_move && !src_ind;
  endsequence

  sequence move_finish_s;
    ##1 MEM_RD_OUT ##1 DONE_OUT;
  endsequence

  move_src_a: assert property (
    move_issue_s |-> move_finish_s and (##1 MEM_RD_ADDR_OUT == $past(ptr[2]) + $past(INSTR_WORD_IN[6:0])))
    else $error("indexed move read the wrong source address");

  move_abs_dest_a: assert property (
    do_move && !move_ss |-> ##2 MEM_WR_OUT && DONE_OUT && MEM_WR_ADDR_OUT == $past(INSTR_WORD2_IN[11:0], 2))
    else $error("absolute move missed its literal destination");

  move_idx_dest_a: assert property (
    do_move && move_ss && !dst_ind |-> ##2 MEM_WR_OUT &&
      MEM_WR_ADDR_OUT == $past(ptr[2], 2) + $past(INSTR_WORD2_IN[6:0], 2))
    else $error("indexed move wrote the wrong destination address");

  ind_src_zero_a: assert property (
    do_move && src_ind |=> !MEM_RD_OUT ##1 MEM_WR_DATA_OUT == ESIE_NULL_DATA)
    else $error("indirect source did not read as zero");

  ind_dest_nop_a: assert property (
    do_move && dst_ind |=> !MEM_WR_OUT ##1 !MEM_WR_OUT && DONE_OUT)
    else $error("indirect destination was written");

  push_store_a: assert property (
    do_push |=> MEM_WR_OUT && MEM_WR_ADDR_OUT == $past(ptr[2]) &&
      MEM_WR_DATA_OUT == $past(INSTR_WORD_IN[7:0]) && ptr[2] == $past(ptr[2]) - ESIE_PTR_ONE)
    else $error("literal push stored or decremented wrongly");

  ptr_sub_a: assert property (
    do_sub && !do_subret |=> DONE_OUT && !PC_LOAD_OUT &&
      ptr[$past(sub_sel)] == $past(ptr[sub_sel]) - $past(sub_k))
    else $error("pointer subtract produced the wrong value");

  sub_return_a: assert property (
    do_subret |=> PC_LOAD_OUT && BUSY_OUT && PC_VALUE_OUT == $past(RETURN_STACK_TOP_IN)
      ##1 DONE_OUT && !PC_LOAD_OUT)
    else $error("subtract-and-return sequence broken");

  ilo_map_a: assert property (
    do_std && ext_en && !INSTR_WORD_IN[ESIE_ACCESS_BIT] && INSTR_WORD_IN[7:0] <= ESIE_ILO_LIMIT
      |=> FILE_VALID_OUT && FILE_ADDR_OUT == $past(ptr[2]) + $past(INSTR_WORD_IN[7:0]))
    else $error("low operand not offset from frame pointer");

  ext_off_a: assert property (
    take && !ext_en |=> FILE_VALID_OUT && !PC_LOAD_OUT && !MEM_WR_OUT && !MEM_RD_OUT)
    else $error("extended behaviour ran while disabled");

  call_reg_a: assert property (
    do_call_work |=> PUSH_OUT && PUSH_VALUE_OUT == $past(PC_IN) + ESIE_PC_STEP &&
      PC_VALUE_OUT[7:0] == $past(WORKING_REGISTER_IN) ##1 DONE_OUT && !PUSH_OUT)
    else $error("call through working register misbehaved");

endmodule

// File: esie_mem_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Data memory on the far side of the executor
// ---------------------------------------------------------------------------
module esie_mem_model (
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic [11:0] rd_addr_in,
  input wire logic wr_in,
  input wire logic [11:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [0:4095];
  logic [7:0] last;

  // Outside a read the bus shows the inverse of the last value, so stale data never matches.
  assign rd_data_out = rd_in ? mem[rd_addr_in] : ~last;

  initial begin
    last = 8'h00;
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end

  always @(posedge clk_in) begin
    if (rd_in) begin
      last <= mem[rd_addr_in];
    end
    if (wr_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/1ns
module testbench
  import esie_pkg::*;
;
  localparam logic [31:0] NO = 32'hFFFF_FFFF;
  logic clk, rst_b, iv, psel, pen, pwr, pready, pslv, mrd, mwr, pld, psh, fv, ftr, busy, done;
  logic [15:0] w1, w2;
  logic [7:0] rdd, work, phl, mwd;
  logic [3:0] bank;
  logic [4:0] pul;
  logic [20:0] pc, rtop, pcv, pshv;
  logic [11:0] paddr, mra, mwa, fa;
  logic [31:0] pwd, prd, ard, aerr, rd_a, wr_a, wr_d, ld_v, ps_v, f_a, f_r;
  int mismatches, n_checks, cycles, ncyc, bz;

  esie_exec i_esie_exec (
    .CLK_IN(clk), .RST_B_IN(rst_b), .INSTR_VALID_IN(iv), .INSTR_WORD_IN(w1),
    .INSTR_WORD2_IN(w2), .MEM_RD_DATA_IN(rdd), .WORKING_REGISTER_IN(work),
    .BANK_SELECT_REGISTER_IN(bank), .PC_IN(pc), .RETURN_STACK_TOP_IN(rtop),
    .PC_HIGH_LATCH_IN(phl), .PC_UPPER_LATCH_IN(pul), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PSTRB_IN(4'hF),
    .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(pslv), .MEM_RD_OUT(mrd),
    .MEM_RD_ADDR_OUT(mra), .MEM_WR_OUT(mwr), .MEM_WR_ADDR_OUT(mwa), .MEM_WR_DATA_OUT(mwd),
    .PC_LOAD_OUT(pld), .PC_VALUE_OUT(pcv), .PUSH_OUT(psh), .PUSH_VALUE_OUT(pshv),
    .FILE_VALID_OUT(fv), .FILE_ADDR_OUT(fa), .FILE_TO_REG_OUT(ftr), .BUSY_OUT(busy),
    .DONE_OUT(done));

  esie_mem_model i_esie_mem_model (
    .clk_in(clk), .rd_in(mrd), .rd_addr_in(mra), .wr_in(mwr), .wr_addr_in(mwa),
    .wr_data_in(mwd), .rd_data_out(rdd));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    ard = prd;
    aerr = {31'h0, pslv};
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] err);
    apb(1'b0, a, 32'h0);
    chk(ard, e);
    chk(aerr, err);
  endtask

  // Offers one instruction and gathers every pulse until the instruction completes.
  task automatic run(input logic [15:0] a, input logic [15:0] b);
    int c;
    rd_a = NO;
    wr_a = NO;
    wr_d = NO;
    ld_v = NO;
    ps_v = NO;
    f_a = NO;
    f_r = NO;
    bz = 0;
    @(posedge clk);
    iv <= 1'b1;
    w1 <= a;
    w2 <= b;
    for (c = 0; c < 6; c++) begin
      @(posedge clk);
      iv <= 1'b0;
      if (mrd === 1'b1) rd_a = {20'h0, mra};
      if (mwr === 1'b1) wr_a = {20'h0, mwa};
      if (mwr === 1'b1) wr_d = {24'h0, mwd};
      if (pld === 1'b1) ld_v = {11'h0, pcv};
      if (psh === 1'b1) ps_v = {11'h0, pshv};
      if (fv === 1'b1) f_a = {20'h0, fa};
      if (fv === 1'b1) f_r = {31'h0, ftr};
      if (busy === 1'b1) bz++;
      if (c > 0 && done === 1'b1) break;
    end
    ncyc = c;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    rd(ESIE_REG_CTRL, 32'h0, 32'h0);
    rd(ESIE_REG_PTR2, 32'h0, 32'h0);
    rd(12'h014, 32'h0, 32'h1);
    apb(1'b1, ESIE_REG_STATUS, 32'h3);
    rd(ESIE_REG_STATUS, 32'h0, 32'h0);
  endtask

  task automatic t_off;
    apb(1'b1, ESIE_REG_PTR2, 32'h200);
    run(16'hFA08, 16'h0);
    chk(wr_a, NO);
    chk(f_a, 32'h008);
    run(16'h2680, 16'h0);
    chk(f_a, 32'hF80);
    bank <= 4'h5;
    run(16'h2730, 16'h0);
    chk(f_a, 32'h530);
  endtask

  task automatic t_move;
    apb(1'b1, ESIE_REG_CTRL, 32'h1);
    apb(1'b1, ESIE_REG_PTR2, 32'h080);
    i_esie_mem_model.mem[12'h085] = 8'h33;
    // Destinations stay clear of the program counter and return-stack bytes.
    run(16'hEB05, 16'hFA22);
    chk(rd_a, 32'h085);
    chk(wr_a, 32'hA22);
    chk(wr_d, 32'h33);
    chk(ncyc, 2);
    chk(bz, 1);
    run(16'hEB85, 16'hF006);
    chk(wr_a, 32'h086);
    chk(wr_d, 32'h33);
    apb(1'b1, ESIE_REG_PTR2, 32'hF80);
    run(16'hEBDB, 16'hF001);
    chk(rd_a, NO);
    chk(wr_a, 32'hF81);
    chk(wr_d, 32'h0);
    run(16'hEB81, 16'hF06F);
    chk(wr_a, NO);
    rd(ESIE_REG_STATUS, 32'h2, 32'h0);
  endtask

  task automatic t_push;
    apb(1'b1, ESIE_REG_PTR2, 32'h0);
    run(16'hFA08, 16'h0);
    chk(wr_a, 32'h0);
    chk(wr_d, 32'h08);
    chk(ncyc, 1);
    chk(bz, 0);
    rd(ESIE_REG_PTR2, 32'hFFF, 32'h0);
  endtask

  task automatic t_sub;
    apb(1'b1, ESIE_REG_PTR0, 32'h010);
    apb(1'b1, ESIE_REG_PTR1, 32'h3FF);
    apb(1'b1, ESIE_REG_PTR2, 32'h3FF);
    run(16'hE93F, 16'h0);
    chk(ncyc, 1);
    run(16'hE963, 16'h0);
    run(16'hE9A3, 16'h0);
    chk(ld_v, NO);
    rd(ESIE_REG_PTR0, 32'hFD1, 32'h0);
    rd(ESIE_REG_PTR1, 32'h3DC, 32'h0);
    rd(ESIE_REG_PTR2, 32'h3DC, 32'h0);
    rtop <= 21'h1_ABCD;
    run(16'hE9E3, 16'h0);
    chk(ld_v, 32'h1_ABCD);
    chk(ncyc, 2);
    chk(bz, 1);
    rd(ESIE_REG_PTR2, 32'h3B9, 32'h0);
  endtask

  task automatic t_ilo;
    apb(1'b1, ESIE_REG_PTR2, 32'hA00);
    run(16'h262C, 16'h0);
    chk(f_a, 32'hA2C);
    chk(f_r, 32'h1);
    run(16'h245F, 16'h0);
    chk(f_a, 32'hA5F);
    chk(f_r, 32'h0);
    run(16'h2660, 16'h0);
    chk(f_a, 32'hF60);
    run(16'h2730, 16'h0);
    chk(f_a, 32'h530);
    apb(1'b1, ESIE_REG_PTR2, 32'h0);
    run(16'h262C, 16'h0);
    chk(f_a, 32'h02C);
  endtask

  task automatic t_call;
    work <= 8'h06;
    phl <= 8'h10;
    pc <= 21'h100;
    run(16'h0014, 16'h0);
    chk(ps_v, 32'h102);
    chk(ld_v, 32'h1006);
    chk(ncyc, 2);
  endtask

  // A second reset in mid-run must drop the extensions back to disabled.
  task automatic t_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ESIE_REG_CTRL, 32'h0, 32'h0);
    run(16'hFA08, 16'h0);
    chk(wr_a, NO);
    chk(f_a, 32'h008);
  endtask

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    {rst_b, iv, psel, pen, pwr, work, phl, bank, pul} = '0;
    {w1, w2, pc, rtop, paddr, pwd} = '0;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_off();
    t_move();
    t_push();
    t_sub();
    t_ilo();
    t_call();
    t_reset();
    report_and_stop();
  end
endmodule
